// ---- verilog/dsld_pkg.sv ----
/*
  dsld_pkg: constants shared by the serial load logic of the converter.
  Assumes a single 100 MHz system clock; every value here is a plain localparam.
*/
package dsld_pkg;

  // word layout
  localparam int WORD_BITS        = 16;
  localparam int DATA_BITS        = 12;
  localparam int COUNT_BITS       = 4;

  // reset, clear and last-count values
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [DATA_BITS-1:0] CODE_RESET  = 12'h000;
  localparam logic [DATA_BITS-1:0] CODE_CLEAR  = 12'h000;
  localparam logic [COUNT_BITS-1:0] COUNT_RESET = 4'h0;
  localparam logic [COUNT_BITS-1:0] COUNT_LAST  = 4'hF;

  // timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int LOAD_PULSE_MIN_NS    = 50;
  localparam int LOAD_PULSE_MIN_CYCLES =
    (LOAD_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser depth and pin group width
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT   = 6;

endpackage

// ---- verilog/dsld_sync.sv ----
/*
  dsld_sync: two flip-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level or a clock far below the system clock rate.
*/
`timescale 1ns/1ps
module dsld_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] pins_i,
  input  wire logic [WIDTH-1:0] reset_value_i,
  output logic      [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  // first stage feeds only the second stage
  always_comb begin
    next_stage1 = pins_i;
    next_stage2 = stage1;
  end

  // reset loads the per-bit pattern driven on the reset_value_i input
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stage1 <= reset_value_i;
      stage2 <= reset_value_i;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pins_o = stage2;

endmodule // dsld_sync

// ---- verilog/dsld_top.sv ----
/*
  dsld_top: serial input, daisy-chain output and latch update of a 12-bit
  converter. Assumes all pins arrive asynchronously and are far slower than
  the 100 MHz clock_i; the serial clock runs at 12.5 MHz or below.
*/
`timescale 1ns/1ps
module dsld_top
  import dsld_pkg::*;
#(
  parameter int WORD_W = dsld_pkg::WORD_BITS,
  parameter int CODE_W = dsld_pkg::DATA_BITS
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              frame_sel_n_i,
  input  wire logic              serial_clk_i,
  input  wire logic              serial_data_i,
  input  wire logic              latch_load_n_i,
  input  wire logic              latch_clear_n_i,
  input  wire logic              chain_enable_i,
  output logic [CODE_W-1:0]      dac_code_o,
  output logic                   serial_data_o,
  output logic                   update_o
);
  import dsld_pkg::*;

  // the datapath below is fixed at the documented word and code widths
  generate
    if (WORD_W != WORD_BITS || CODE_W != DATA_BITS) begin : g_width_check
      $error("dsld_top supports only a 16-bit word and a 12-bit code");
    end
  endgenerate

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_sync;
  logic                 frame_n_s;
  logic                 sclk_s;
  logic                 sdin_s;
  logic                 load_n_s;
  logic                 clear_n_s;
  logic                 chain_s;

  assign pins_raw = {chain_enable_i, latch_clear_n_i, latch_load_n_i,
                     serial_data_i, serial_clk_i, frame_sel_n_i};

  // every pin is resynchronised before any logic looks at it
  dsld_sync #(
    .WIDTH (PIN_COUNT)
  ) u_sync (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .pins_i        (pins_raw),
    .reset_value_i (6'h1F),                                 // chain idles low, rest high
    .pins_o        (pins_sync)
  );

  assign frame_n_s = pins_sync[0];
  assign sclk_s    = pins_sync[1];
  assign sdin_s    = pins_sync[2];
  assign load_n_s  = pins_sync[3];
  assign clear_n_s = pins_sync[4];
  assign chain_s   = pins_sync[5];

  // edge history of the synchronised clock and latch load
  logic sclk_prev;
  logic load_prev;
  logic next_sclk_prev;
  logic next_load_prev;
  logic sclk_fall;
  logic load_fall;

  always_comb begin
    next_sclk_prev = sclk_s;
    next_load_prev = load_n_s;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sclk_prev <= 1'b1;
      load_prev <= 1'b1;
    end else begin
      sclk_prev <= next_sclk_prev;
      load_prev <= next_load_prev;
    end
  end

  assign sclk_fall = sclk_prev & ~sclk_s;
  // a 50 ns low pulse spans five clocks, enough for the synchroniser
  assign load_fall = load_prev & ~load_n_s;

  // shift register and bit counter
  logic [WORD_BITS-1:0]  shift;
  logic [COUNT_BITS-1:0] count;
  logic [WORD_BITS-1:0]  next_shift;
  logic [COUNT_BITS-1:0] next_count;
  logic                  shift_en;
  logic                  word_done;

  assign shift_en  = sclk_fall & ~frame_n_s;
  assign word_done = shift_en & (count == COUNT_LAST);

  always_comb begin
    next_shift = shift;
    next_count = count;
    if (frame_n_s) begin
      next_count = COUNT_RESET;
    end else if (shift_en) begin
      // msb arrives first, so each new bit enters at the bottom
      next_shift = {shift[WORD_BITS-2:0], sdin_s};
      next_count = COUNT_BITS'(count + 1'b1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      shift <= SHIFT_RESET;
      count <= COUNT_RESET;
    end else begin
      shift <= next_shift;
      count <= next_count;
    end
  end

  // daisy-chain output: the bit leaving the top stage feeds the next device
  logic sdout;
  logic next_sdout;

  always_comb begin
    next_sdout = 1'b0;
    if (chain_s) begin
      next_sdout = shift[WORD_BITS-1];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sdout <= 1'b0;
    end else begin
      sdout <= next_sdout;
    end
  end

  // latch: clear beats any update, auto update uses the freshly shifted word
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] next_code;
  logic              upd;
  logic              next_upd;
  logic              auto_upd;

  // every sixteenth framed edge in auto mode; in a chain the latch load pin
  // is normally pulsed instead, so repeat updates there are harmless
  assign auto_upd = word_done & ~load_n_s;

  always_comb begin
    next_code = code;
    next_upd  = 1'b0;
    if (!clear_n_s) begin
      next_code = CODE_CLEAR;
    end else if (auto_upd) begin
      next_code = next_shift[CODE_W-1:0];
      next_upd  = 1'b1;
    end else if (load_fall) begin
      next_code = shift[CODE_W-1:0];
      next_upd  = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      code <= CODE_RESET;
      upd  <= 1'b0;
    end else begin
      code <= next_code;
      upd  <= next_upd;
    end
  end

  assign dac_code_o    = code;
  assign serial_data_o = sdout;
  assign update_o      = upd;

  // checks next to the logic
  shift_on_edge_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    shift_en |=> shift == {$past(shift[WORD_BITS-2:0]), $past(sdin_s)})
    else $error("shift register did not take the sampled bit");

  idle_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    frame_n_s |=> $stable(shift) && count == COUNT_RESET)
    else $error("shift path moved while frame select was high");

  bit_count_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    shift_en |=> count == COUNT_BITS'($past(count) + 1'b1))
    else $error("bit counter did not advance on a framed edge");

  auto_update_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (word_done && !load_n_s && clear_n_s) |=> code == shift[CODE_W-1:0] && upd)
    else $error("automatic update missed on the sixteenth edge");

  load_edge_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (load_fall && clear_n_s && !auto_upd) |=> code == $past(shift[CODE_W-1:0]))
    else $error("latch load falling edge did not update the latch");

  short_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ($fell(load_n_s) && clear_n_s) ##1 !load_n_s [*4] |-> $past(upd, 3))
    else $error("a minimum width load pulse gave no update");

  clear_zero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !clear_n_s |=> code == CODE_CLEAR && !upd)
    else $error("clear did not force zeros into the latch");

  latch_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (clear_n_s && !auto_upd && !load_fall) |=> $stable(code))
    else $error("latch changed without clear or update");

  chain_out_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    chain_s |=> serial_data_o == $past(shift[WORD_BITS-1]))
    else $error("chain output does not follow the top stage");

  chain_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !chain_s |=> !serial_data_o)
    else $error("serial data out driven with chaining off");

endmodule // dsld_top

// ---- verif/dsld_host_model.sv ----
/*
  dsld_host_model: serial transmit port of the host feeding the converter.
  Assumes clock_i is the 100 MHz system clock; one link period is 8 of its cycles.
*/
`timescale 1ns/1ps
module dsld_host_model (
  input  wire logic        clock_i,
  input  wire logic        chain_in_i,
  output logic             frame_sel_n_o,
  output logic             serial_clk_o,
  output logic             serial_data_o,
  output logic [31:0]      echo_o
);
  // idle pins: frame high, clock parked high
  initial begin
    frame_sel_n_o = 1'b1;
    serial_clk_o  = 1'b1;
    serial_data_o = 1'b0;
    echo_o        = 32'h0;
  end

  // half a link period, 40 ns
  task automatic half();
    repeat (4) @(negedge clock_i);
  endtask

  // frame opens before any clock edge of the word
  task automatic open_frame();
    frame_sel_n_o <= 1'b0;
    half();
  endtask

  // released data line shows no stale bit
  task automatic close_frame();
    frame_sel_n_o <= 1'b1;
    serial_data_o <= ~serial_data_o;
    half();
  endtask

  // msb first; data moves on the rise so it is steady over the fall
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_clk_o  <= 1'b1;
      serial_data_o <= bits[i];
      echo_o        <= {echo_o[30:0], chain_in_i};
      half();
      serial_clk_o <= 1'b0;
      half();
    end
    serial_clk_o <= 1'b1;
    echo_o       <= {echo_o[30:0], chain_in_i};
    half();
  endtask
endmodule // dsld_host_model

// ---- verif/testbench.sv ----
/*
  testbench: drives one converter through auto, chained and cleared updates.
  Assumes the host model owns frame, serial clock and serial data pins.
*/
`timescale 1ns/1ps
module testbench;
  import dsld_pkg::*;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        frame_sel_n_i;
  logic        serial_clk_i;
  logic        serial_data_i;
  logic        latch_load_n_i = 1'b1;
  logic        latch_clear_n_i = 1'b1;
  logic        chain_enable_i = 1'b0;
  logic [11:0] dac_code_o;
  logic        serial_data_o;
  logic        update_o;
  logic [31:0] echo;
  int          fail_count = 0;
  int          n_checks = 0;
  int          upd_cnt = 0;

  always #5 clock_i = ~clock_i;

  dsld_top i_dsld_top (
    .clock_i(clock_i), .resetn_i(resetn_i), .frame_sel_n_i(frame_sel_n_i),
    .serial_clk_i(serial_clk_i), .serial_data_i(serial_data_i),
    .latch_load_n_i(latch_load_n_i), .latch_clear_n_i(latch_clear_n_i),
    .chain_enable_i(chain_enable_i), .dac_code_o(dac_code_o),
    .serial_data_o(serial_data_o), .update_o(update_o)
  );

  dsld_host_model i_dsld_host_model (
    .clock_i(clock_i), .chain_in_i(serial_data_o), .frame_sel_n_o(frame_sel_n_i),
    .serial_clk_o(serial_clk_i), .serial_data_o(serial_data_i), .echo_o(echo)
  );

  // count latch loads seen on the one-cycle pulse
  always @(posedge clock_i) begin
    if (update_o === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // latch load pulse of exactly the 50 ns minimum
  task automatic load_pulse();
    latch_load_n_i <= 1'b0;
    repeat (5) @(negedge clock_i);
    latch_load_n_i <= 1'b1;
    repeat (4) @(negedge clock_i);
  endtask

  // byte-split word, auto update only on the sixteenth edge
  task automatic t_auto();
    latch_load_n_i <= 1'b0;
    // pulling the pin low into auto mode is itself a latch load edge
    repeat (8) @(negedge clock_i);
    check(16'(upd_cnt), 16'h1);
    check(16'(dac_code_o), 16'h0);
    i_dsld_host_model.open_frame();
    i_dsld_host_model.send(32'hA5, 8);
    i_dsld_host_model.send(32'h61, 7);
    check(16'(upd_cnt), 16'h1);
    i_dsld_host_model.send(32'h1, 1);
    check(16'(upd_cnt), 16'h2);
    check(16'(dac_code_o), 16'h05C3);
    check(16'(serial_data_o), 16'h0);
    i_dsld_host_model.close_frame();
    // unframed edges must neither shift nor count
    i_dsld_host_model.send(32'hFFFF, 16);
    check(16'(upd_cnt), 16'h2);
    check(16'(dac_code_o), 16'h05C3);
  endtask

  // two words through the chain, then one shared load pulse
  task automatic t_chain();
    latch_load_n_i <= 1'b1;
    chain_enable_i <= 1'b1;
    i_dsld_host_model.open_frame();
    i_dsld_host_model.send(32'h9ABC1234, 32);
    i_dsld_host_model.close_frame();
    check(echo[16:1], 16'h9ABC);
    check(16'(upd_cnt), 16'h2);
    load_pulse();
    check(16'(upd_cnt), 16'h3);
    check(16'(dac_code_o), 16'h0234);
  endtask

  // clear forces zero and beats a load pulse
  task automatic t_clear();
    latch_clear_n_i <= 1'b0;
    repeat (4) @(negedge clock_i);
    check(16'(dac_code_o), 16'h0);
    load_pulse();
    check(16'(upd_cnt), 16'h3);
    check(16'(dac_code_o), 16'h0);
    latch_clear_n_i <= 1'b1;
  endtask

  // watchdog: the whole run needs well under 20 us
  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (4) @(negedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(negedge clock_i);
    check(16'(dac_code_o), 16'h0);
    check(16'(update_o), 16'h0);
    t_auto();
    t_chain();
    t_clear();
    final_report();
  end
endmodule // testbench
